// ---- rtw_timer.sv ----
// Ripple timer with overflow flag, periodic tick, watchdog and reset delays.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
module rtw_timer #(
  parameter bit WATCHDOG_EN = 1'b1,
  parameter bit POR_SHORT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [rtw_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_reset_pin_n,
  input wire logic stop_enter,
  input wire logic stop_wake_irq,
  input wire logic [7:0] user_eeprom_byte,
  output logic timer_irq,
  output logic device_reset
);
  import rtw_pkg::*;

  // ****************************************************************
  // External reset pin synchroniser
  // ****************************************************************
  logic [2:0] pin_sync_r;
  logic ext_rst_r;
  logic ext_rst_nxt;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_r <= 3'h7;
      ext_rst_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], ext_reset_pin_n};
      ext_rst_r <= ext_rst_nxt;
    end
  end

  // A change counts only once the two later stages agree.
  assign ext_rst_nxt = (pin_sync_r[2] == pin_sync_r[1]) ? ~pin_sync_r[2] : ext_rst_r;

  // ****************************************************************
  // Bus slave: one wait cycle, then the answer
  // ****************************************************************
  logic wait_r;
  logic [31:0] rdata_r;
  logic bus_req;
  logic bus_done;
  logic wr_done;
  logic sel_csr;
  logic sel_count;
  logic sel_wdg;
  logic lane0;
  logic [7:0] rd_byte;

  rtw_csr_t csr_r;
  rtw_csr_t csr_nxt;
  logic [CHAIN_W-1:0] chain_r;
  logic [CHAIN_W-1:0] chain_nxt;
  logic [WDG_W-1:0] wdg_r;
  logic [WDG_W-1:0] wdg_nxt;
  rtw_state_t state_r;
  rtw_state_t state_nxt;
  logic [DLY_W-1:0] dly_r;
  logic [DLY_W-1:0] dly_nxt;
  logic irq_r;
  logic devrst_r;
  logic devrst_nxt;

  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~wait_r;
  assign wr_done = avs_write & ~wait_r;
  assign sel_csr = (avs_address == ADDR_CSR);
  assign sel_count = (avs_address == ADDR_COUNT);
  assign sel_wdg = (avs_address == ADDR_WDG_CLR);
  assign lane0 = avs_byteenable[0];

  // Acknowledge bits and bits 3:2 always read zero; the count is live.
  assign rd_byte = sel_csr ? {csr_r.ovf_flag, csr_r.per_flag, csr_r.ovf_irq_enable,
                              csr_r.per_irq_enable, 2'b00, csr_r.periodic_rate_select} :
                   sel_count ? chain_r[PRE_W +: CNT_W] :
                   sel_wdg ? user_eeprom_byte :
                   8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(bus_req & wait_r);
      if (bus_req && wait_r) begin
        rdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  logic wr_csr;
  logic ovf_ack;
  logic per_ack;
  logic wdg_clear;

  assign wr_csr = wr_done & sel_csr & lane0;
  assign ovf_ack = wr_csr & avs_writedata[BIT_OVF_ACK];
  assign per_ack = wr_csr & avs_writedata[BIT_PER_ACK];
  // The shared user byte itself is not touched by this write.
  assign wdg_clear = wr_done & sel_wdg & lane0 & ~avs_writedata[BIT_WDG_CLR];

  // ****************************************************************
  // Counter chain and taps
  // ****************************************************************
  logic running;
  logic chain_clear;
  logic soft_reset;
  logic ovf_tick;
  logic [3:0] tap_tick;
  logic per_tick;
  logic wdg_timeout;

  // The chain ignores processor wait and halt; only stop and resets touch it.
  assign running = (state_r == ST_RUN) || (state_r == ST_POR) || (state_r == ST_WAKE);
  assign ovf_tick = (state_r == ST_RUN) && (&chain_r[PRE_W+CNT_W-1:0]);

  // Carry into stage 14+k marks tap k; bits 16:10 are the seven extra stages.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tap
      assign tap_tick[gi] = &chain_r[PER_BASE+gi-1:0];
    end
  endgenerate

  assign per_tick = (state_r == ST_RUN) && tap_tick[csr_r.periodic_rate_select];
  assign wdg_timeout = WATCHDOG_EN && wdg_r[WDG_W-1];
  assign soft_reset = ext_rst_r || wdg_timeout;
  assign chain_clear = soft_reset || (state_nxt != state_r) || (state_r == ST_STOP);

  // Prescaler bits 1:0 divide by four ahead of the visible count.
  assign chain_nxt = chain_clear ? '0 : running ? chain_r + 1'b1 : chain_r;

  // Only the last four bits are cleared by software; earlier stages keep counting.
  assign wdg_nxt = (chain_clear || wdg_clear) ? '0 :
                   (per_tick ? wdg_r + 1'b1 : wdg_r);

  // ****************************************************************
  // Power-on, stop and wake sequencing
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    dly_nxt = dly_r;
    unique case (state_r)
      ST_POR: begin
        dly_nxt = dly_r - 1'b1;
        if (dly_r == '0) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_enter && !soft_reset) begin
          state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        if (stop_wake_irq || ext_rst_r) begin
          state_nxt = ST_WAKE;
          dly_nxt = POR_SHORT ? DLY_SHORT : DLY_LONG;
        end
      end
      ST_WAKE: begin
        dly_nxt = dly_r - 1'b1;
        if (dly_r == '0) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_POR;
        dly_nxt = POR_SHORT ? DLY_SHORT : DLY_LONG;
      end
    endcase
  end

  // ****************************************************************
  // Control/status register
  // ****************************************************************
  always_comb begin
    csr_nxt = csr_r;
    if (wr_csr) begin
      csr_nxt.ovf_irq_enable = avs_writedata[BIT_OVF_IE];
      csr_nxt.per_irq_enable = avs_writedata[BIT_PER_IE];
      csr_nxt.periodic_rate_select = avs_writedata[1:0];
    end
    // Flags ignore direct writes; a hardware set beats a same-cycle acknowledge.
    csr_nxt.ovf_flag = ovf_tick | (csr_r.ovf_flag & ~ovf_ack);
    csr_nxt.per_flag = per_tick | (csr_r.per_flag & ~per_ack);
    if (soft_reset) begin
      csr_nxt = '{ovf_flag: 1'b0, per_flag: 1'b0, ovf_irq_enable: 1'b0,
                  per_irq_enable: 1'b0, periodic_rate_select: RATE_RESET};
    end
  end

  // Internal reset stays high through power-on delay, pin reset and watchdog.
  assign devrst_nxt = (state_nxt == ST_POR) || soft_reset;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      csr_r <= '{ovf_flag: 1'b0, per_flag: 1'b0, ovf_irq_enable: 1'b0,
                 per_irq_enable: 1'b0, periodic_rate_select: RATE_RESET};
      chain_r <= '0;
      wdg_r <= '0;
      state_r <= ST_POR;
      dly_r <= POR_SHORT ? DLY_SHORT : DLY_LONG;
      irq_r <= 1'b0;
      devrst_r <= 1'b1;
    end else begin
      csr_r <= csr_nxt;
      chain_r <= chain_nxt;
      wdg_r <= wdg_nxt;
      state_r <= state_nxt;
      dly_r <= dly_nxt;
      irq_r <= (csr_r.ovf_flag & csr_r.ovf_irq_enable) |
               (csr_r.per_flag & csr_r.per_irq_enable);
      devrst_r <= devrst_nxt;
    end
  end

  assign timer_irq = irq_r;
  assign device_reset = devrst_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_count_step;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_RUN) && !chain_clear && (chain_r[1:0] == 2'h3) |=>
      chain_r[PRE_W +: CNT_W] == $past(chain_r[PRE_W +: CNT_W]) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_count_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_RUN) && !chain_clear && (chain_r[1:0] != 2'h3) |=>
      $stable(chain_r[PRE_W +: CNT_W]);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved early");

  property p_ovf_set;
    @(posedge clk_sys) disable iff (!rst_n)
    ovf_tick && !soft_reset |=> csr_r.ovf_flag ##0 (chain_r[PRE_W +: CNT_W] == 8'h00);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
    (csr_r.per_flag && csr_r.per_irq_enable) || (csr_r.ovf_flag && csr_r.ovf_irq_enable)
      |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("timer interrupt missing");

  property p_ovf_ack;
    @(posedge clk_sys) disable iff (!rst_n)
    ovf_ack && !ovf_tick |=> !csr_r.ovf_flag;
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("overflow acknowledge failed");

  property p_per_ack;
    @(posedge clk_sys) disable iff (!rst_n)
    per_ack && !per_tick |=> !csr_r.per_flag;
  endproperty
  a_per_ack: assert property (p_per_ack) else $error("periodic acknowledge failed");

  property p_csr_zero_bits;
    @(posedge clk_sys) disable iff (!rst_n)
    (avs_read && wait_r && sel_csr) |=> !avs_waitrequest ##0 (avs_readdata[3:2] == 2'b00);
  endproperty
  a_csr_zero_bits: assert property (p_csr_zero_bits) else $error("bits 3:2 not zero");

  property p_reset_vals;
    @(posedge clk_sys) disable iff (!rst_n)
    soft_reset |=> (csr_r.periodic_rate_select == RATE_RESET) && !csr_r.ovf_flag &&
      !csr_r.per_flag && !csr_r.ovf_irq_enable && !csr_r.per_irq_enable;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_wdg_reset;
    @(posedge clk_sys) disable iff (!rst_n)
    WATCHDOG_EN && wdg_r[WDG_W-1] |=> device_reset && (wdg_r == '0);
  endproperty
  a_wdg_reset: assert property (p_wdg_reset) else $error("watchdog reset missing");

  property p_wdg_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    wdg_clear && !chain_clear |=> (wdg_r == '0) && (chain_r == $past(chain_r) + 1'b1);
  endproperty
  a_wdg_clear: assert property (p_wdg_clear) else $error("watchdog clear wrong");

  property p_stop_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_STOP) |=> (chain_r == '0);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("chain not cleared in stop");

  property p_count_ro;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_done && sel_count && !chain_clear |=>
      chain_r == $past(chain_r) + 1'b1;
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count write was not ignored");

  property p_ovf_wr_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_csr && !avs_writedata[BIT_OVF_ACK] && !ovf_tick && !soft_reset |=>
      csr_r.ovf_flag == $past(csr_r.ovf_flag);
  endproperty
  a_ovf_wr_ignored: assert property (p_ovf_wr_ignored) else $error("overflow flag written");

  property p_per_wr_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_csr && !avs_writedata[BIT_PER_ACK] && !per_tick && !soft_reset |=>
      csr_r.per_flag == $past(csr_r.per_flag);
  endproperty
  a_per_wr_ignored: assert property (p_per_wr_ignored) else $error("periodic flag written");

  property p_per_set;
    @(posedge clk_sys) disable iff (!rst_n)
    per_tick && !soft_reset |=>
      csr_r.per_flag;
  endproperty
  a_per_set: assert property (p_per_set) else $error("periodic flag not set on tap");

  property p_wdg_count;
    @(posedge clk_sys) disable iff (!rst_n)
    per_tick && !chain_clear && !wdg_clear |=>
      wdg_r == $past(wdg_r) + 4'h1;
  endproperty
  a_wdg_count: assert property (p_wdg_count) else $error("watchdog missed a tick");

  property p_por_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_POR) && (dly_r != '0) |=>
      device_reset;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset released during delay");

  property p_por_release;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_POR) && (dly_r == '0) && !soft_reset |=>
      (state_r == ST_RUN) && (chain_r == '0) && !device_reset;
  endproperty
  a_por_release: assert property (p_por_release) else $error("power-on release wrong");

  property p_ext_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    ext_rst_r |=>
      (chain_r == '0) && device_reset;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("pin reset did not clear chain");

  property p_stop_entry;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_RUN) && stop_enter && !soft_reset |=>
      (state_r == ST_STOP) && (chain_r == '0);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry did not clear chain");

  property p_wake_end;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_WAKE) && (dly_r == '0) |=>
      (state_r == ST_RUN) && (chain_r == '0);
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake end did not clear chain");

endmodule

// ---- rtw_pkg.sv ----
// Constants, types and register map of the ripple timer with periodic tick and watchdog.
package rtw_pkg;

  // ****************************************************************
  // Register map (index times four gives the byte address)
  // ****************************************************************
  localparam logic [9:0] IDX_CSR = 10'h008;
  localparam logic [9:0] IDX_COUNT = 10'h009;
  localparam logic [9:0] IDX_WDG_CLR = 10'h3f0;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CSR = {IDX_CSR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WDG_CLR = {IDX_WDG_CLR, 2'b00};

  // ****************************************************************
  // Control/status field positions and reset values
  // ****************************************************************
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_PER_FLAG = 6;
  localparam int BIT_OVF_IE = 5;
  localparam int BIT_PER_IE = 4;
  localparam int BIT_OVF_ACK = 3;
  localparam int BIT_PER_ACK = 2;
  localparam int BIT_WDG_CLR = 0;
  localparam logic [1:0] RATE_RESET = 2'h3;

  // ****************************************************************
  // Chain geometry and timing counts, in timer clock cycles
  // ****************************************************************
  localparam int PRE_W = 2;
  localparam int CNT_W = 8;
  localparam int CHAIN_W = 17;
  localparam int PER_BASE = 14;
  localparam int WDG_W = 4;
  localparam int POR_LONG_CYCLES = 4064;
  localparam int POR_SHORT_CYCLES = 16;
  localparam int DLY_W = 12;
  localparam logic [DLY_W-1:0] DLY_LONG = DLY_W'(POR_LONG_CYCLES - 1);
  localparam logic [DLY_W-1:0] DLY_SHORT = DLY_W'(POR_SHORT_CYCLES - 1);

  typedef enum logic [3:0] {
    ST_POR = 4'b0001,
    ST_RUN = 4'b0010,
    ST_STOP = 4'b0100,
    ST_WAKE = 4'b1000
  } rtw_state_t;

  typedef struct packed {
    logic ovf_flag;
    logic per_flag;
    logic ovf_irq_enable;
    logic per_irq_enable;
    logic [1:0] periodic_rate_select;
  } rtw_csr_t;

endpackage

// ---- tb_ripple_timer_rti_watchdog.sv ----
// Self-checking bench for the ripple timer with periodic tick and watchdog.
`timescale 1ns/10ps
module tb_ripple_timer_rti_watchdog;
  import rtw_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic be;
    logic [7:0] wdata;
    logic [7:0] mask;
    logic [7:0] expv;
  } rtw_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_reset_pin_n = 1'b1;
  logic stop_enter = 1'b0;
  logic stop_wake_irq = 1'b0;
  logic [7:0] user_eeprom_byte = 8'h5a;
  logic timer_irq;
  logic device_reset;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int t1;
  int t2;
  logic [7:0] rd;
  logic [7:0] rd2;
  logic [7:0] dc;
  rtw_row_t rows [7];

  // The short power-on delay keeps the run well inside its cycle budget.
  rtw_timer #(.WATCHDOG_EN(1'b1), .POR_SHORT(1'b1)) rtw_timer_i (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ext_reset_pin_n(ext_reset_pin_n),
    .stop_enter(stop_enter),
    .stop_wake_irq(stop_wake_irq),
    .user_eeprom_byte(user_eeprom_byte),
    .timer_irq(timer_irq),
    .device_reset(device_reset)
  );

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
  end

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] expv);
    n_checks++;
    if (got !== expv) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, expv);
    end
  endtask

  // Every transfer starts on a fresh edge, so back-to-back calls never drive a strobe twice.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic be, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'h0, be};
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata[7:0];
    if (n >= 100) chk(32'h0, 32'h1);
    if (!wr) chk({8'h0, avs_readdata[31:8]}, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 1'b1, q);
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, 1'b1, q);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Polls one control bit and keeps the watchdog fed while it waits.
  task automatic wait_bit(input int b, output int t);
    int n;
    logic [7:0] q;
    n = 0;
    do begin
      rdr(ADDR_CSR, q);
      n++;
      if (n % 1024 == 0) wr(ADDR_WDG_CLR, 8'h00);
    end while (q[b] !== 1'b1 && n < 7000);
    t = cyc;
    chk({31'h0, q[b]}, 32'h1);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    ticks(80000);
    err_total++;
    $display("[FAIL] %0t ns: run did not finish", $time);
    print_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // A watchdog timeout needs eight ticks of at least 16384 cycles, beyond the run budget.
  initial begin
    rows = '{'{ADDR_CSR, 1'b1, 8'h3f, 8'h3f, 8'h33},
             '{ADDR_CSR, 1'b1, 8'h01, 8'h3f, 8'h01},
             '{ADDR_CSR, 1'b1, 8'h02, 8'h3f, 8'h02},
             '{ADDR_CSR, 1'b1, 8'h00, 8'h3f, 8'h00},
             '{ADDR_CSR, 1'b0, 8'h33, 8'h3f, 8'h00},
             '{ADDR_WDG_CLR, 1'b1, 8'h01, 8'hff, 8'h5a},
             '{12'h100, 1'b1, 8'hff, 8'hff, 8'h00}};
    ticks(3);
    chk({31'h0, device_reset}, 32'h1);
    chk({31'h0, timer_irq}, 32'h0);
    rst_n <= 1'b1;
    t1 = cyc;
    while (device_reset !== 1'b0 && cyc - t1 < 100) @(posedge clk_sys);
    chk({31'h0, (cyc - t1 >= POR_SHORT_CYCLES - 1) && (cyc - t1 <= POR_SHORT_CYCLES + 4)}, 32'h1);
    rdr(ADDR_CSR, rd);
    chk({24'h0, rd}, {30'h0, RATE_RESET});
    rdr(ADDR_COUNT, rd);
    t1 = cyc;
    ticks(101);
    wr(ADDR_COUNT, 8'h00);
    rdr(ADDR_COUNT, rd2);
    t2 = cyc;
    dc = rd2 - rd;
    chk({31'h0, (int'(dc) * 4 >= t2 - t1 - 3) && (int'(dc) * 4 <= t2 - t1 + 3)}, 32'h1);
    // The rows move the rate taps, so the watchdog is fed first.
    wr(ADDR_WDG_CLR, 8'h00);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, rd);
      rdr(rows[i].addr, rd);
      chk({24'h0, rd & rows[i].mask}, {24'h0, rows[i].expv});
    end
    wr(ADDR_CSR, 8'h08);
    wait_bit(BIT_OVF_FLAG, t1);
    rdr(ADDR_COUNT, rd);
    chk({31'h0, rd < 8'h04}, 32'h1);
    chk({31'h0, timer_irq}, 32'h0);
    wr(ADDR_CSR, 8'ha0);
    ticks(2);
    chk({31'h0, timer_irq}, 32'h1);
    rdr(ADDR_CSR, rd);
    chk({31'h0, rd[BIT_OVF_FLAG]}, 32'h1);
    wr(ADDR_CSR, 8'h28);
    rdr(ADDR_CSR, rd);
    chk({24'h0, rd & 8'h88}, 32'h0);
    ticks(2);
    chk({31'h0, timer_irq}, 32'h0);
    wr(ADDR_CSR, 8'h04);
    wait_bit(BIT_PER_FLAG, t1);
    wr(ADDR_CSR, 8'h50);
    ticks(2);
    chk({31'h0, timer_irq}, 32'h1);
    rdr(ADDR_CSR, rd);
    chk({31'h0, rd[BIT_PER_FLAG]}, 32'h1);
    wr(ADDR_CSR, 8'h04);
    rdr(ADDR_CSR, rd);
    chk({24'h0, rd & 8'h44}, 32'h0);
    wait_bit(BIT_PER_FLAG, t2);
    chk({31'h0, (t2 - t1 >= (1 << PER_BASE) - 12) && (t2 - t1 <= (1 << PER_BASE) + 12)}, 32'h1);
    chk({31'h0, device_reset}, 32'h0);
    wr(ADDR_CSR, 8'h30);
    ext_reset_pin_n <= 1'b0;
    ticks(8);
    chk({31'h0, device_reset}, 32'h1);
    ext_reset_pin_n <= 1'b1;
    t1 = cyc;
    while (device_reset !== 1'b0 && cyc - t1 < 100) @(posedge clk_sys);
    rdr(ADDR_CSR, rd);
    chk({24'h0, rd}, {30'h0, RATE_RESET});
    rdr(ADDR_COUNT, rd);
    chk({31'h0, rd < 8'h0c}, 32'h1);
    stop_enter <= 1'b1;
    ticks(1);
    stop_enter <= 1'b0;
    ticks(8);
    rdr(ADDR_COUNT, rd);
    ticks(20);
    rdr(ADDR_COUNT, rd2);
    chk({24'h0, rd | rd2}, 32'h0);
    stop_wake_irq <= 1'b1;
    ticks(1);
    stop_wake_irq <= 1'b0;
    // The chain runs through the wake delay and is cleared as it ends, so look just after.
    ticks(POR_SHORT_CYCLES);
    rdr(ADDR_COUNT, rd);
    chk({24'h0, rd}, 32'h0);
    ticks(40);
    rdr(ADDR_COUNT, rd);
    chk({31'h0, (rd >= 8'h04) && (rd <= 8'h0e)}, 32'h1);
    print_verdict();
  end
endmodule
